// ==== verilog/phy_cfg_pkg.sv ====
package phy_cfg_pkg;
	// Register map
	localparam logic [7:0] CFG_OFFSET = 8'h10;
	localparam logic [7:0] STATUS_OFFSET = 8'h11;
	// Field positions in the config register
	localparam int SPEED_LED_DISABLE_BIT = 6;
	localparam int COLLISION_LED_SELECT_BIT = 5;
	localparam int AUTO_LOW_POWER_ENABLE_BIT = 4;
	localparam int STATE_MACHINE_RESET_BIT = 3;
	localparam int MGMT_PREAMBLE_SKIP_BIT = 2;
	localparam int SLEEP_BIT = 1;
	localparam int REMOTE_LOOP_OUT_BIT = 0;
	// Value after reset
	localparam logic [15:0] CFG_RESET = 16'h0014;
	// State machine reset pulse length
	localparam int SM_RESET_NS = 200;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SM_RESET_CYCLES = (SM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SM_RESET_COUNT = 4'(SM_RESET_CYCLES);

	typedef struct packed {
		logic speed_led_disable;
		logic collision_led_select;
		logic auto_low_power_enable;
		logic mgmt_preamble_skip;
		logic sleep;
		logic remote_loop_out;
	} cfg_s;

	typedef struct packed {
		logic full_duplex;
		logic collision;
		logic speed_100;
		logic signal_detect;
	} link_status_s;
endpackage

// ==== verilog/sm_reset_timer.sv ====
`timescale 1ns/10ps
// Stretches a one-cycle reset request into a fixed-length reset pulse
module sm_reset_timer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic start,
	output logic active
);
	logic [3:0] count;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 4'h0;
		end else if (ce) begin
			if (start) begin
				count <= phy_cfg_pkg::SM_RESET_COUNT;
			end else if (count != 4'h0) begin
				count <= count - 4'h1;
			end
		end
	end

	assign active = (count != 4'h0);
endmodule

// ==== verilog/phy_specific_config.sv ====
`timescale 1ns/10ps
module phy_specific_config (
	// Clock, reset, enable
	input wire logic MCLK_I,
	input wire logic ARST_N_I,
	input wire logic CE_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	// Link status from the transceiver core, asynchronous
	input wire logic FULL_DUPLEX_I,
	input wire logic COLLISION_I,
	input wire logic SPEED_100_I,
	input wire logic SIGNAL_DETECT_I,
	// Receive data for loop-out, same clock
	input wire logic [3:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	// Transmit path from the MAC side, same clock
	input wire logic [3:0] MAC_TX_DATA_I,
	input wire logic MAC_TX_VALID_I,
	output logic [3:0] TX_DATA_O,
	output logic TX_VALID_O,
	// Controls to the core
	output logic STATE_MACHINE_RESET_O,
	output logic SLEEP_O,
	output logic AUTO_LOW_POWER_ENABLE_O,
	output logic MGMT_PREAMBLE_SKIP_O,
	// LEDs
	output logic DUPLEX_COLLISION_LED_OUT_O,
	output logic SPEED_LED_OUT_O
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	phy_cfg_pkg::link_status_s status_meta;
	phy_cfg_pkg::link_status_s status_sync;
	phy_cfg_pkg::link_status_s status_raw;

	assign status_raw = '{FULL_DUPLEX_I, COLLISION_I, SPEED_100_I, SIGNAL_DETECT_I};

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			status_meta <= '0;
			status_sync <= '0;
		end else if (CE_I) begin
			status_meta <= status_raw;
			status_sync <= status_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction

	wire cfg_wr = CE_I && WR_I && hit(ADDR_I, phy_cfg_pkg::CFG_OFFSET);
	wire cfg_rd = RD_I && hit(ADDR_I, phy_cfg_pkg::CFG_OFFSET);
	wire stat_rd = RD_I && hit(ADDR_I, phy_cfg_pkg::STATUS_OFFSET);

	wire wr_smr = WDATA_I[phy_cfg_pkg::STATE_MACHINE_RESET_BIT];
	wire wr_sleep = WDATA_I[phy_cfg_pkg::SLEEP_BIT];

	phy_cfg_pkg::cfg_s cfg;
	phy_cfg_pkg::cfg_s next_cfg;
	// Configuration bits keep their value across sleep; the waking write loads every field from WDATA_I
	assign next_cfg = cfg_wr ? '{
		WDATA_I[phy_cfg_pkg::SPEED_LED_DISABLE_BIT],
		WDATA_I[phy_cfg_pkg::COLLISION_LED_SELECT_BIT],
		WDATA_I[phy_cfg_pkg::AUTO_LOW_POWER_ENABLE_BIT],
		WDATA_I[phy_cfg_pkg::MGMT_PREAMBLE_SKIP_BIT],
		wr_sleep,
		WDATA_I[phy_cfg_pkg::REMOTE_LOOP_OUT_BIT]
	} : cfg;

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			// Reset fields picked from the register reset word, constants only
			cfg <= '{
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::SPEED_LED_DISABLE_BIT],
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::COLLISION_LED_SELECT_BIT],
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::AUTO_LOW_POWER_ENABLE_BIT],
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::MGMT_PREAMBLE_SKIP_BIT],
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::SLEEP_BIT],
				phy_cfg_pkg::CFG_RESET[phy_cfg_pkg::REMOTE_LOOP_OUT_BIT]
			};
		end else if (CE_I) begin
			cfg <= next_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State machine reset: software request or wake from sleep
	wire wake = cfg_wr && cfg.sleep && !wr_sleep;
	wire smr_start = (cfg_wr && wr_smr) || wake;
	logic smr_active;

	sm_reset_timer u_timer (
		.clk(MCLK_I),
		.arst_n(ARST_N_I),
		.ce(CE_I),
		.start(smr_start),
		.active(smr_active)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read data
	wire [15:0] cfg_word = {9'h000, cfg.speed_led_disable, cfg.collision_led_select,
		cfg.auto_low_power_enable, smr_active, cfg.mgmt_preamble_skip, cfg.sleep,
		cfg.remote_loop_out};
	wire [15:0] stat_word = {12'h000, status_sync};
	wire [15:0] next_rdata = cfg_rd ? cfg_word : (stat_rd ? stat_word : 16'h0000);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RDATA_O <= 16'h0000;
		end else if (CE_I) begin
			RDATA_O <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs: LEDs and loop-out
	// While asleep or in reset the core is down, so LEDs go dark
	wire quiet = cfg.sleep || smr_active;
	wire next_dc_led = quiet ? 1'b0 : (cfg.collision_led_select ?
		(status_sync.full_duplex || status_sync.collision) : status_sync.full_duplex);
	wire next_sp_led = quiet ? 1'b0 : (cfg.speed_led_disable ?
		status_sync.signal_detect : status_sync.speed_100);
	wire [3:0] next_tx_data = cfg.remote_loop_out ? RX_DATA_I : MAC_TX_DATA_I;
	wire next_tx_valid = !quiet && (cfg.remote_loop_out ? RX_VALID_I : MAC_TX_VALID_I);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DUPLEX_COLLISION_LED_OUT_O <= 1'b0;
			SPEED_LED_OUT_O <= 1'b0;
			TX_DATA_O <= 4'h0;
			TX_VALID_O <= 1'b0;
		end else if (CE_I) begin
			DUPLEX_COLLISION_LED_OUT_O <= next_dc_led;
			SPEED_LED_OUT_O <= next_sp_led;
			TX_DATA_O <= next_tx_data;
			TX_VALID_O <= next_tx_valid;
		end
	end

	assign STATE_MACHINE_RESET_O = smr_active;
	assign SLEEP_O = cfg.sleep;
	assign AUTO_LOW_POWER_ENABLE_O = cfg.auto_low_power_enable;
	assign MGMT_PREAMBLE_SKIP_O = cfg.mgmt_preamble_skip;
endmodule

// ==== verification/phy_cfg_sva.sv ====
`timescale 1ns/10ps
module phy_cfg_sva (
	// Clock, reset, bus
	input wire logic MCLK_I,
	input wire logic ARST_N_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	// Outputs watched
	input wire logic STATE_MACHINE_RESET_O,
	input wire logic SLEEP_O,
	input wire logic AUTO_LOW_POWER_ENABLE_O,
	input wire logic MGMT_PREAMBLE_SKIP_O,
	input wire logic TX_VALID_O,
	input wire logic DUPLEX_COLLISION_LED_OUT_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);
	wire wr = CE_I && WR_I && ADDR_I == phy_cfg_pkg::CFG_OFFSET;
	a_reset_starts: assert property (wr && WDATA_I[3] |=> STATE_MACHINE_RESET_O)
		else $error("reset pulse missing");
	// Pulse length assumes no restart and clock enable held high
	a_reset_length: assert property ($rose(STATE_MACHINE_RESET_O) && CE_I |->
		STATE_MACHINE_RESET_O [*5] ##1 !STATE_MACHINE_RESET_O) else $error("bad pulse length");
	a_sleep_follows: assert property (wr |=> SLEEP_O == $past(WDATA_I[1]))
		else $error("sleep not written");
	a_wake_resets: assert property (wr && SLEEP_O && !WDATA_I[1] |=> STATE_MACHINE_RESET_O)
		else $error("wake without reset");
	a_low_power_write: assert property (wr |=> AUTO_LOW_POWER_ENABLE_O == $past(WDATA_I[4]))
		else $error("low power bit wrong");
	a_preamble_held: assert property (!wr |=> $stable(MGMT_PREAMBLE_SKIP_O))
		else $error("preamble bit moved");
	a_tx_quiet: assert property (SLEEP_O && $past(SLEEP_O) |-> !TX_VALID_O)
		else $error("tx active in sleep");
	a_led_dark: assert property (SLEEP_O && $past(SLEEP_O) |-> !DUPLEX_COLLISION_LED_OUT_O)
		else $error("led lit in sleep");
endmodule
bind phy_specific_config phy_cfg_sva chk_u (.MCLK_I, .ARST_N_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I,
	.STATE_MACHINE_RESET_O, .SLEEP_O, .AUTO_LOW_POWER_ENABLE_O, .MGMT_PREAMBLE_SKIP_O,
	.TX_VALID_O, .DUPLEX_COLLISION_LED_OUT_O);

// ==== verification/test_phy_specific_config.sv ====
`timescale 1ns/10ps
module test_phy_specific_config;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
	logic fdx = 1'b0, col = 1'b1, spd = 1'b1, sdet = 1'b0, rxv = 1'b1, mtv = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [3:0] rxd = 4'hA, mtd = 4'h5, txd;
	logic txv, smr, slp, alp, mps, led_d, led_s;
	int miscompares = 0, check_count = 0, cyc = 0, n;
	always #20 clk = ~clk;
	phy_specific_config dut_u (.MCLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FULL_DUPLEX_I(fdx),
		.COLLISION_I(col), .SPEED_100_I(spd), .SIGNAL_DETECT_I(sdet), .RX_DATA_I(rxd),
		.RX_VALID_I(rxv), .MAC_TX_DATA_I(mtd), .MAC_TX_VALID_I(mtv), .TX_DATA_O(txd),
		.TX_VALID_O(txv), .STATE_MACHINE_RESET_O(smr), .SLEEP_O(slp),
		.AUTO_LOW_POWER_ENABLE_O(alp), .MGMT_PREAMBLE_SKIP_O(mps),
		.DUPLEX_COLLISION_LED_OUT_O(led_d), .SPEED_LED_OUT_O(led_s));
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
		@(posedge clk) wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk) begin rd <= 1'b1; addr <= a; end
		@(posedge clk) rd <= 1'b0;
		#1 check("rdata", rdata, e);
	endtask
	task wait_n(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task t_reset;
		rd_chk(8'h10, 16'h0014);
		rd_chk(8'h20, 16'h0000);
		wr_reg(8'h10, 16'h0000);
		wait_n(1);
		check("alp", 16'(alp), 16'h0000);
		check("mps", 16'(mps), 16'h0000);
		wr_reg(8'h10, 16'h0014);
	endtask
	task t_smr;
		wr_reg(8'h10, 16'h001C);
		#1 n = 0;
		while (smr === 1'b1 && n < 20) begin
			n++;
			wait_n(1);
		end
		check("smr_len", 16'(n), 16'h0005);
		rd_chk(8'h10, 16'h0014);
		// Bit reads high while the pulse runs
		wr_reg(8'h10, 16'h001C);
		rd_chk(8'h10, 16'h001C);
		wait_n(4);
		rd_chk(8'h10, 16'h0014);
	endtask
	task t_led;
		wr_reg(8'h10, 16'h0014);
		wait_n(4);
		check("dup_led", 16'(led_d), 16'h0000);
		check("spd_led", 16'(led_s), 16'h0001);
		wr_reg(8'h10, 16'h0074);
		wait_n(4);
		check("dup_led", 16'(led_d), 16'h0001);
		check("spd_led", 16'(led_s), 16'h0000);
		rd_chk(8'h11, 16'h0006);
	endtask
	task t_loop;
		wr_reg(8'h10, 16'h0015);
		wait_n(2);
		check("txd", 16'(txd), 16'h000A);
		wr_reg(8'h10, 16'h0014);
		wait_n(2);
		check("txd", 16'(txd), 16'h0005);
	endtask
	// Write with clock enable low must be ignored
	task t_freeze;
		@(posedge clk) ce <= 1'b0;
		wr_reg(8'h10, 16'h0000);
		@(posedge clk) ce <= 1'b1;
		rd_chk(8'h10, 16'h0014);
	endtask
	task t_sleep;
		wr_reg(8'h10, 16'h0036);
		wait_n(3);
		check("sleep", 16'(slp), 16'h0001);
		check("txv", 16'(txv), 16'h0000);
		wr_reg(8'h10, 16'h0034);
		#1 check("smr", 16'(smr), 16'h0001);
		wait_n(8);
		rd_chk(8'h10, 16'h0034);
		check("txv", 16'(txv), 16'h0001);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_smr();
		t_led();
		t_loop();
		t_freeze();
		t_sleep();
		complete_run();
	end
endmodule
